//--- hw/rcf_pkg.sv
// package of constants for the reset cause flag register bank
// Notes on behaviour
// RULE1: overflow bit7, underflow bit6, pin reset bit3, instruction bit2, power-on bit1, brown-out bit0.
// RULE2: stack overflow sets its flag, except in a power-on or brown-out cycle; firmware may write it one or zero.
// RULE3: a stack underflow sets the underflow flag, except in a cycle with a power-on or brown-out event.
// RULE4: firmware writing zero clears the underflow flag until the next underflow.
// RULE5: external pin reset clears its flag, except in a power-on or brown-out cycle; firmware may write one to re-arm.
// RULE6: reset instruction clears its flag, except in a power-on or brown-out cycle; a firmware one holds until then.
// RULE7: power-on reset drives its flag to zero; firmware writes one afterwards.
// RULE8: brown-out reset clears its flag; firmware sets it after power-on or brown-out.
// RULE9: bits 5 and 4 read zero and ignore writes.
// RULE10: power events load stack flags zero, pin and instruction flags one.
// RULE11: stack faults request a reset only when the stack reset enable is set.
// RULE12: a hardware set or clear beats a firmware write in the same cycle.
package rcf_pkg;
	localparam int unsigned ADDR_W   = 4;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned FLAG_W   = 8;
	localparam int unsigned EVT_W    = 6;

	// register byte offsets
	localparam logic [3:0] OFS_CAUSE   = 4'h0;
	localparam logic [3:0] OFS_IRQ_ST  = 4'h4;
	localparam logic [3:0] OFS_IRQ_CLR = 4'h8;
	localparam logic [3:0] OFS_IRQ_EN  = 4'hC;

	// flag positions in the cause register
	localparam int unsigned BIT_STK_OVF = 7;
	localparam int unsigned BIT_STK_UNF = 6;
	localparam int unsigned BIT_PIN_RST = 3;
	localparam int unsigned BIT_RST_INS = 2;
	localparam int unsigned BIT_POR     = 1;
	localparam int unsigned BIT_BOR     = 0;

	// implemented and writable bits of the cause register
	localparam logic [7:0] CAUSE_MASK  = 8'hCF;
	// value after power-on: stack flags 0, pin and instruction 1, power-on 0, brown-out 0
	localparam logic [7:0] CAUSE_RESET = 8'h0C;

	// event positions in the interrupt status register
	localparam int unsigned EVT_STK_OVF = 0;
	localparam int unsigned EVT_STK_UNF = 1;
	localparam int unsigned EVT_PIN_RST = 2;
	localparam int unsigned EVT_RST_INS = 3;
	localparam int unsigned EVT_POR     = 4;
	localparam int unsigned EVT_BOR     = 5;

	localparam logic [5:0]  IRQ_EN_RESET = 6'h00;
	localparam logic [5:0]  IRQ_ST_RESET = 6'h00;
	localparam logic [31:0] RDATA_IDLE   = 32'h0000_0000;
endpackage : rcf_pkg

//--- hw/rcf_irq.sv
// sticky interrupt status with enable gating
`timescale 1ns/1ps
`default_nettype none
module rcf_irq (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_resetn,
	input  wire logic [rcf_pkg::EVT_W-1:0] i_event,
	input  wire logic [rcf_pkg::EVT_W-1:0] i_clear,
	input  wire logic                    i_en_wr,
	input  wire logic [rcf_pkg::EVT_W-1:0] i_en_wdata,
	output logic      [rcf_pkg::EVT_W-1:0] o_status,
	output logic      [rcf_pkg::EVT_W-1:0] o_enable,
	output logic                         o_irq
);

	logic [rcf_pkg::EVT_W-1:0] status_reg;
	logic [rcf_pkg::EVT_W-1:0] status_next;
	logic [rcf_pkg::EVT_W-1:0] enable_reg;
	logic [rcf_pkg::EVT_W-1:0] enable_next;

	////////////////////////////////////////////////////////////////////////
	// per bit: set wins over clear
	genvar g;
	generate
		for (g = 0; g < rcf_pkg::EVT_W; g++) begin : g_bit
			always_comb begin
				if (i_event[g]) begin
					status_next[g] = 1'b1;
				end else if (i_clear[g]) begin
					status_next[g] = 1'b0;
				end else begin
					status_next[g] = status_reg[g];
				end
			end
		end
	endgenerate

	always_comb begin
		enable_next = enable_reg;
		if (i_en_wr) begin
			enable_next = i_en_wdata;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			status_reg <= rcf_pkg::IRQ_ST_RESET;
			enable_reg <= rcf_pkg::IRQ_EN_RESET;
		end else begin
			status_reg <= status_next;
			enable_reg <= enable_next;
		end
	end

	assign o_status = status_reg;
	assign o_enable = enable_reg;
	assign o_irq    = |(status_reg & enable_reg);

endmodule // rcf_irq
`default_nettype wire

//--- hw/rcf_reset_cause.sv
// reset cause flag register with register port and event interrupt
`timescale 1ns/1ps
`default_nettype none
module rcf_reset_cause (
	input  wire logic                      i_core_clk,
	input  wire logic                      i_resetn,
	// register port
	input  wire logic [rcf_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [rcf_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                      i_wr,
	input  wire logic                      i_rd,
	output logic      [rcf_pkg::DATA_W-1:0] o_rdata,
	// reset events, one-cycle pulses
	input  wire logic                      i_power_on_event,
	input  wire logic                      i_brown_out_event,
	input  wire logic                      i_external_reset_pin_event,
	input  wire logic                      i_reset_instruction_event,
	input  wire logic                      i_stack_overflow_event,
	input  wire logic                      i_stack_underflow_event,
	// configuration level
	input  wire logic                      i_stack_reset_enable,
	// outputs
	output logic      [rcf_pkg::FLAG_W-1:0] o_reset_cause,
	output logic                           o_stack_reset_req,
	output logic                           o_irq
);

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [rcf_pkg::FLAG_W-1:0] cause_reg;
	logic [rcf_pkg::FLAG_W-1:0] cause_next;
	logic [rcf_pkg::FLAG_W-1:0] hw_set;
	logic [rcf_pkg::FLAG_W-1:0] hw_clr;
	logic [rcf_pkg::FLAG_W-1:0] hw_hit;
	logic [rcf_pkg::FLAG_W-1:0] wr_mask;
	logic [rcf_pkg::FLAG_W-1:0] wr_val;
	logic                       power_evt;

	logic [rcf_pkg::DATA_W-1:0] rdata_reg;
	logic [rcf_pkg::DATA_W-1:0] rdata_next;

	logic                       stk_req_reg;
	logic                       stk_req_next;

	logic                       sel_cause;
	logic                       sel_irq_st;
	logic                       sel_irq_clr;
	logic                       sel_irq_en;

	logic [rcf_pkg::EVT_W-1:0]  irq_event;
	logic [rcf_pkg::EVT_W-1:0]  irq_clear;
	logic [rcf_pkg::EVT_W-1:0]  irq_status;
	logic [rcf_pkg::EVT_W-1:0]  irq_enable;

	////////////////////////////////////////////////////////////////////////
	// address decode
	always_comb begin
		sel_cause   = 1'b0;
		sel_irq_st  = 1'b0;
		sel_irq_clr = 1'b0;
		sel_irq_en  = 1'b0;
		if (i_addr == rcf_pkg::OFS_CAUSE) begin
			sel_cause = 1'b1;
		end else if (i_addr == rcf_pkg::OFS_IRQ_ST) begin
			sel_irq_st = 1'b1;
		end else if (i_addr == rcf_pkg::OFS_IRQ_CLR) begin
			sel_irq_clr = 1'b1;
		end else if (i_addr == rcf_pkg::OFS_IRQ_EN) begin
			sel_irq_en = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// hardware set and clear terms per flag
	always_comb begin
		power_evt = i_power_on_event | i_brown_out_event;
		hw_set    = '0;
		hw_clr    = '0;
		if (power_evt) begin
			hw_clr[rcf_pkg::BIT_STK_OVF] = 1'b1; // RULE10
			hw_clr[rcf_pkg::BIT_STK_UNF] = 1'b1; // RULE10
			hw_set[rcf_pkg::BIT_PIN_RST] = 1'b1; // RULE10
			hw_set[rcf_pkg::BIT_RST_INS] = 1'b1; // RULE10
		end else begin
			hw_set[rcf_pkg::BIT_STK_OVF] = i_stack_overflow_event; // RULE2
			hw_set[rcf_pkg::BIT_STK_UNF] = i_stack_underflow_event; // RULE3
			hw_clr[rcf_pkg::BIT_PIN_RST] = i_external_reset_pin_event; // RULE5
			hw_clr[rcf_pkg::BIT_RST_INS] = i_reset_instruction_event; // RULE6
		end
		hw_clr[rcf_pkg::BIT_POR] = i_power_on_event; // RULE7
		hw_clr[rcf_pkg::BIT_BOR] = i_brown_out_event; // RULE8
		hw_hit = hw_set | hw_clr;
	end

	////////////////////////////////////////////////////////////////////////
	// firmware write terms, reserved bits masked off
	always_comb begin
		wr_mask = '0;
		wr_val  = i_wdata[rcf_pkg::FLAG_W-1:0];
		if (i_wr && sel_cause) begin
			wr_mask = rcf_pkg::CAUSE_MASK; // RULE9
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flag next value: hardware first, then firmware, then hold
	always_comb begin
		cause_next = cause_reg;
		for (int b = 0; b < rcf_pkg::FLAG_W; b++) begin
			if (hw_hit[b]) begin
				cause_next[b] = hw_set[b]; // RULE12
			end else if (wr_mask[b]) begin
				cause_next[b] = wr_val[b]; // RULE4
			end
		end
		cause_next = cause_next & rcf_pkg::CAUSE_MASK; // RULE9
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cause_reg <= rcf_pkg::CAUSE_RESET; // RULE10
		end else begin
			cause_reg <= cause_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stack reset request, gated by the configuration enable
	always_comb begin
		stk_req_next = i_stack_reset_enable &
			(i_stack_overflow_event | i_stack_underflow_event); // RULE11
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			stk_req_reg <= 1'b0;
		end else begin
			stk_req_reg <= stk_req_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt events and clears
	always_comb begin
		irq_event = '0;
		irq_event[rcf_pkg::EVT_STK_OVF] = i_stack_overflow_event;
		irq_event[rcf_pkg::EVT_STK_UNF] = i_stack_underflow_event;
		irq_event[rcf_pkg::EVT_PIN_RST] = i_external_reset_pin_event;
		irq_event[rcf_pkg::EVT_RST_INS] = i_reset_instruction_event;
		irq_event[rcf_pkg::EVT_POR]     = i_power_on_event;
		irq_event[rcf_pkg::EVT_BOR]     = i_brown_out_event;
		irq_clear = '0;
		if (i_wr && sel_irq_clr) begin
			irq_clear = i_wdata[rcf_pkg::EVT_W-1:0];
		end
	end

	rcf_irq u_irq (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_event    (irq_event),
		.i_clear    (irq_clear),
		.i_en_wr    (i_wr && sel_irq_en),
		.i_en_wdata (i_wdata[rcf_pkg::EVT_W-1:0]),
		.o_status   (irq_status),
		.o_enable   (irq_enable),
		.o_irq      (o_irq)
	);

	////////////////////////////////////////////////////////////////////////
	// read data: one cycle after the strobe, zero otherwise
	always_comb begin
		rdata_next = rcf_pkg::RDATA_IDLE;
		if (i_rd) begin
			if (sel_cause) begin
				rdata_next[rcf_pkg::FLAG_W-1:0] = cause_reg; // RULE1
			end else if (sel_irq_st) begin
				rdata_next[rcf_pkg::EVT_W-1:0] = irq_status;
			end else if (sel_irq_en) begin
				rdata_next[rcf_pkg::EVT_W-1:0] = irq_enable;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_reg <= rcf_pkg::RDATA_IDLE;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_rdata           = rdata_reg;
	assign o_reset_cause     = cause_reg;
	assign o_stack_reset_req = stk_req_reg;

endmodule // rcf_reset_cause
`default_nettype wire

//--- tb/rcf_reset_cause_checker.sv
// concurrent checks for the reset cause flag register
`timescale 1ns/1ps
`default_nettype none
module rcf_reset_cause_checker (
	input wire logic        i_core_clk,
	input wire logic        i_resetn,
	input wire logic [3:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic        i_power_on_event,
	input wire logic        i_brown_out_event,
	input wire logic        i_external_reset_pin_event,
	input wire logic        i_reset_instruction_event,
	input wire logic        i_stack_overflow_event,
	input wire logic        i_stack_underflow_event,
	input wire logic        i_stack_reset_enable,
	input wire logic [7:0]  o_reset_cause,
	input wire logic        o_stack_reset_req,
	input wire logic        o_irq
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	logic pwr;
	logic evt;
	logic stk;
	assign pwr = i_power_on_event | i_brown_out_event;
	assign stk = i_stack_overflow_event | i_stack_underflow_event;
	assign evt = pwr | stk | i_external_reset_pin_event | i_reset_instruction_event;
	sequence s_fault;
		stk & i_stack_reset_enable;
	endsequence
	a_unused_zero: assert property (o_reset_cause[5:4] == 2'h0) else $error("unused bits set");
	a_ovf_sets: assert property (i_stack_overflow_event & !pwr |=> o_reset_cause[7]) else $error("ovf");
	a_unf_sets: assert property (i_stack_underflow_event & !pwr |=> o_reset_cause[6]) else $error("unf");
	a_pin_clears: assert property (i_external_reset_pin_event & !pwr |=> !o_reset_cause[3]) else $error("pin");
	a_ins_clears: assert property (i_reset_instruction_event & !pwr |=> !o_reset_cause[2]) else $error("ins");
	a_por_load: assert property (i_power_on_event & !i_brown_out_event |=> o_reset_cause[7:1] == 7'h06
		&& o_reset_cause[0] == $past(o_reset_cause[0])) else $error("power-on load");
	a_bor_load: assert property (i_brown_out_event & !i_power_on_event |=> o_reset_cause[7:2] == 6'h03
		&& !o_reset_cause[0] && o_reset_cause[1] == $past(o_reset_cause[1])) else $error("brown-out load");
	a_req_fault: assert property (s_fault |=> o_stack_reset_req) else $error("no stack reset");
	a_req_only: assert property (!(stk & i_stack_reset_enable) |=> !o_stack_reset_req) else $error("stray req");
	a_write_store: assert property (i_wr && i_addr == rcf_pkg::OFS_CAUSE && !evt
		|=> o_reset_cause == ($past(i_wdata[7:0]) & rcf_pkg::CAUSE_MASK)) else $error("write lost");
	a_read_back: assert property (i_rd && i_addr == rcf_pkg::OFS_CAUSE
		|=> o_rdata == {24'h00_0000, $past(o_reset_cause)}) else $error("read data");
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0000_0000) else $error("read data not idle");
	a_irq_cleared: assert property (i_wr && i_addr == rcf_pkg::OFS_IRQ_CLR && i_wdata[5:0] == 6'h3F && !evt
		|=> !o_irq) else $error("interrupt not cleared");
endmodule // rcf_reset_cause_checker
bind rcf_reset_cause rcf_reset_cause_checker i_chk (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_power_on_event(i_power_on_event),
	.i_brown_out_event(i_brown_out_event), .i_external_reset_pin_event(i_external_reset_pin_event),
	.i_reset_instruction_event(i_reset_instruction_event), .i_stack_overflow_event(i_stack_overflow_event),
	.i_stack_underflow_event(i_stack_underflow_event), .i_stack_reset_enable(i_stack_reset_enable),
	.o_reset_cause(o_reset_cause), .o_stack_reset_req(o_stack_reset_req), .o_irq(o_irq));
`default_nettype wire

//--- tb/rcf_reset_cause_tb_top.sv
// testbench for the reset cause flag register
`timescale 1ns/1ps
`default_nettype none
module rcf_reset_cause_tb_top;
	localparam logic [3:0] ca = rcf_pkg::OFS_CAUSE;
	logic        i_core_clk, i_resetn, i_wr, i_rd, en, o_stack_reset_req, o_irq;
	logic [3:0]  i_addr;
	logic [31:0] i_wdata, o_rdata;
	logic [5:0]  ev;
	logic [7:0]  o_reset_cause;
	int          num_errors, compares;
	rcf_reset_cause i_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_power_on_event(ev[4]), .i_brown_out_event(ev[5]),
		.i_external_reset_pin_event(ev[2]), .i_reset_instruction_event(ev[3]), .i_stack_overflow_event(ev[0]),
		.i_stack_underflow_event(ev[1]), .i_stack_reset_enable(en), .o_reset_cause(o_reset_cause),
		.o_stack_reset_req(o_stack_reset_req), .o_irq(o_irq));
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cause(input logic [31:0] exp);
		chk(32'(o_reset_cause), exp);
	endtask
	task automatic step(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [5:0] e, input logic s);
		@(posedge i_core_clk);
		i_wr <= w;
		i_addr <= a;
		i_wdata <= d;
		ev <= e;
		en <= s;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		ev <= 6'h00;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask
	task automatic close_out;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	initial begin
		#100000;
		num_errors++;
		close_out();
	end
	initial begin
		i_resetn = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		en = 1'b0;
		i_addr = 4'h0;
		i_wdata = 32'h0000_0000;
		ev = 6'h00;
		num_errors = 0;
		compares = 0;
		repeat (8) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		#1;
		cause(32'h0000_000C);
		rd(ca, 32'h0000_000C);
		step(1'b1, ca, 32'hFFFF_FFFF, 6'h00, 1'b0);
		rd(ca, 32'h0000_00CF);
		step(1'b1, ca, 32'h0000_0000, 6'h00, 1'b0);
		rd(ca, 32'h0000_0000);
		step(1'b0, ca, 32'h0000_0000, 6'h01, 1'b1);
		cause(32'h0000_0080);
		chk(32'(o_stack_reset_req), 32'h0000_0001);
		step(1'b0, ca, 32'h0000_0000, 6'h02, 1'b0);
		cause(32'h0000_00C0);
		chk(32'(o_stack_reset_req), 32'h0000_0000);
		step(1'b1, ca, 32'h0000_0040, 6'h00, 1'b0);
		cause(32'h0000_0040);
		step(1'b1, ca, 32'h0000_0000, 6'h00, 1'b0);
		cause(32'h0000_0000);
		step(1'b1, ca, 32'h0000_0000, 6'h03, 1'b1);
		cause(32'h0000_00C0);
		step(1'b1, ca, 32'h0000_00FF, 6'h04, 1'b0);
		cause(32'h0000_00C7);
		step(1'b1, ca, 32'h0000_000F, 6'h00, 1'b0);
		step(1'b0, ca, 32'h0000_0000, 6'h04, 1'b0);
		cause(32'h0000_0007);
		step(1'b0, ca, 32'h0000_0000, 6'h08, 1'b0);
		cause(32'h0000_0003);
		step(1'b1, ca, 32'h0000_00C3, 6'h00, 1'b0);
		step(1'b0, ca, 32'h0000_0000, 6'h10, 1'b0);
		cause(32'h0000_000D);
		step(1'b1, ca, 32'h0000_00C3, 6'h00, 1'b0);
		step(1'b0, ca, 32'h0000_0000, 6'h20, 1'b0);
		cause(32'h0000_000E);
		step(1'b1, rcf_pkg::OFS_IRQ_EN, 32'h0000_003F, 6'h00, 1'b0);
		rd(rcf_pkg::OFS_IRQ_EN, 32'h0000_003F);
		chk(32'(o_irq), 32'h0000_0001);
		rd(rcf_pkg::OFS_IRQ_ST, 32'h0000_003F);
		step(1'b1, rcf_pkg::OFS_IRQ_CLR, 32'h0000_003F, 6'h00, 1'b0);
		chk(32'(o_irq), 32'h0000_0000);
		rd(rcf_pkg::OFS_IRQ_ST, 32'h0000_0000);
		rd(rcf_pkg::OFS_IRQ_CLR, 32'h0000_0000);
		step(1'b1, rcf_pkg::OFS_IRQ_EN, 32'h0000_0001, 6'h00, 1'b0);
		step(1'b0, ca, 32'h0000_0000, 6'h02, 1'b0);
		chk(32'(o_irq), 32'h0000_0000);
		step(1'b0, ca, 32'h0000_0000, 6'h01, 1'b0);
		chk(32'(o_irq), 32'h0000_0001);
		step(1'b1, 4'h2, 32'h0000_0000, 6'h00, 1'b0);
		rd(4'h2, 32'h0000_0000);
		rd(ca, 32'h0000_00CE);
		step(1'b1, ca, 32'h0000_00CE, 6'h11, 1'b0);
		cause(32'h0000_000C);
		chk(32'(o_irq), 32'h0000_0001);
		@(posedge i_core_clk);
		i_resetn <= 1'b0;
		#1;
		chk(32'(o_irq), 32'h0000_0000);
		cause(32'h0000_000C);
		repeat (2) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		#1;
		rd(rcf_pkg::OFS_IRQ_EN, 32'h0000_0000);
		rd(ca, 32'h0000_000C);
		close_out();
	end
endmodule // rcf_reset_cause_tb_top
`default_nettype wire
